// >>> design/sync_align_pkg.sv
// Constants shared by the sync delay aligner and its sequencer.
// Assumes a register port with word-aligned byte addresses.
package sync_align_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] DELAY_BASE = 8'h10;
    localparam logic [7:0] CHCFG_BASE = 8'h20;

    // Control register fields
    localparam int CTRL_LIVE_BIT = 0;
    localparam int CTRL_PARALLEL_BIT = 1;
    localparam int CTRL_START_LSB = 4;

    // Status register fields
    localparam int STATUS_BUSY_LSB = 0;
    localparam int STATUS_NEED_LSB = 4;

    // Channel configuration fields
    localparam int CHCFG_RATIO_LSB = 0;
    localparam int CHCFG_NEG_BIT = 4;
    localparam int CHCFG_DECIM_LSB = 8;

    // Widths and limits
    localparam int CHANNELS = 4;
    localparam int RELAYED = 2;
    localparam int DELAY_W = 9;
    localparam logic [8:0] DELAY_MAX = 9'h100;
    localparam logic [7:0] HOLD_MAX = 8'h10;

    // Reset values
    localparam logic [8:0] DELAY_RESET = 9'h000;
    localparam logic [2:0] RATIO_RESET = 3'h1;
    localparam logic [7:0] DECIM_RESET = 8'h04;

    typedef enum logic [2:0] {
        seq_idle,
        seq_arm,
        seq_fire,
        seq_wait,
        seq_done
    } seq_state_type;

endpackage

// >>> design/sync_seq_if.sv
// Handshake between the register logic and one channel's sync sequencer.
// One instance per channel; driven on the single high-speed clock.
`timescale 1ns/1ps
interface sync_seq_if;
    logic start;
    logic [8:0] delay;
    logic busy;
    logic done;
    logic sync_en;
    logic duc_pulse;
    logic ddc_pulse;

    modport ctl (
        output start,
        output delay,
        input busy,
        input done,
        input sync_en,
        input duc_pulse,
        input ddc_pulse
    );
    modport seq (
        input start,
        input delay,
        output busy,
        output done,
        output sync_en,
        output duc_pulse,
        output ddc_pulse
    );
endinterface

// >>> design/sync_pulse_seq.sv
// One channel's sync sequence: enable, up-converter pulse, delay, down-converter pulse.
// Assumes start is a one-cycle pulse and delay stays stable while busy.
`timescale 1ns/1ps
module sync_pulse_seq
    import sync_align_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Control side
    sync_seq_if.seq ctl
);

    seq_state_type state_ff;
    seq_state_type nxt_state;
    logic [8:0] cnt_ff;
    logic [8:0] nxt_cnt;
    logic duc_ff;
    logic ddc_ff;
    logic nxt_duc;
    logic nxt_ddc;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_duc = 1'b0;
        nxt_ddc = 1'b0;
        case (state_ff)
            seq_idle: begin
                // [RULE14] Start arms sync
                if (ctl.start) begin
                    nxt_state = seq_arm;
                end
            end
            seq_arm: begin
                nxt_state = seq_fire;
            end
            seq_fire: begin
                // [RULE10] Up-converter pulses here; with zero delay the down-converter pulses in the same cycle
                nxt_duc = 1'b1;
                nxt_cnt = ctl.delay;
                if (ctl.delay == 9'h000) begin
                    nxt_ddc = 1'b1;
                    nxt_state = seq_done;
                end else begin
                    nxt_state = seq_wait;
                end
            end
            seq_wait: begin
                // [RULE11] Count high-speed cycles
                nxt_cnt = cnt_ff - 9'h001;
                if (cnt_ff == 9'h001) begin
                    nxt_ddc = 1'b1;
                    nxt_state = seq_done;
                end
            end
            seq_done: begin
                nxt_state = seq_idle;
            end
            default: begin
                nxt_state = seq_idle;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff <= seq_idle;
            cnt_ff <= 9'h000;
            duc_ff <= 1'b0;
            ddc_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            duc_ff <= nxt_duc;
            ddc_ff <= nxt_ddc;
        end
    end

    // [RULE14] Sync disabled on return to idle after done
    assign ctl.sync_en = (state_ff != seq_idle);
    assign ctl.busy = (state_ff != seq_idle);
    assign ctl.done = (state_ff == seq_done);
    assign ctl.duc_pulse = duc_ff;
    assign ctl.ddc_pulse = ddc_ff;

endmodule

// >>> design/sync_delay_aligner.sv
// Sync delay aligner between a down-converter and an up-converter.
// Assumes all converter inputs are synchronous to clock; one clock domain.
// How it works
// [RULE1] Four-channel mode relays I/Q interleaved, one path
// [RULE2] Alignment only via delay between sync pulses
// [RULE3] Parallel mode, decimation over 16 needs sync
// [RULE4] Drive sync onto both converters' channel inputs
// [RULE5] Converters resync channel with fixed latency
// [RULE6] Delay programmable from zero to 256 cycles
// [RULE7] Channels 1-2 latched on divided output clocks
// [RULE8] Relayed channels step by whole divided periods
// [RULE9] Divided clock polarity selectable per relayed channel
// [RULE10] Delay only postpones down-converter sync
// [RULE11] Delay counted in high-speed clock cycles
// [RULE12] Channels 3-4 step by one cycle
// [RULE13] Live update applies new delay immediately; the code ignores a live write's start while the channel's sequencer is busy
// [RULE14] Delay change: enable, pulse both, disable
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module sync_delay_aligner
    import sync_align_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Converter sync inputs
    output logic [CHANNELS-1:0] ddc_channel_sync_input,
    output logic [CHANNELS-1:0] duc_channel_sync_input,
    output logic [CHANNELS-1:0] sync_enable,
    // Relayed down-converter data, channels 1 and 2
    input wire logic [RELAYED-1:0] ddc_div_clk,
    input wire logic [RELAYED-1:0][DATA_W-1:0] ddc_i_data,
    input wire logic [RELAYED-1:0][DATA_W-1:0] ddc_q_data,
    // Relayed data toward the up-converter
    output logic [RELAYED-1:0][DATA_W-1:0] duc_i_data,
    output logic [RELAYED-1:0][DATA_W-1:0] duc_q_data,
    output logic [RELAYED-1:0] duc_data_strobe
);

    // Register decode helper: matches the byte address of a channel register
    function automatic logic hit_channel(
        input logic [7:0] addr,
        input logic [7:0] base,
        input int ch
    );
        logic [7:0] want;
        want = base + 8'(ch * 4);
        return addr == want;
    endfunction

    // Control state
    logic live_ff;
    logic parallel_iq_mode_ff;
    logic [CHANNELS-1:0] need_sync_ff;
    logic [CHANNELS-1:0] nxt_need_sync;
    logic [CHANNELS-1:0][8:0] delay_ff;
    logic [CHANNELS-1:0][2:0] ratio_ff;
    logic [CHANNELS-1:0] neg_pol_ff;
    logic [CHANNELS-1:0][7:0] decim_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // Decoded accesses
    wire ctrl_wr = reg_wr && (reg_addr == CTRL_OFFSET);
    wire ctrl_rd = reg_rd && (reg_addr == CTRL_OFFSET);
    wire status_rd = reg_rd && (reg_addr == STATUS_OFFSET);
    logic [CHANNELS-1:0] delay_wr;
    logic [CHANNELS-1:0] delay_rd;
    logic [CHANNELS-1:0] cfg_wr;
    logic [CHANNELS-1:0] cfg_rd;
    logic [CHANNELS-1:0] start;
    logic [CHANNELS-1:0] busy;
    logic [CHANNELS-1:0] done;
    logic [CHANNELS-1:0] needs_check;
    logic [CHANNELS-1:0][8:0] eff_delay;

    // [RULE6] Clamp to the largest delay
    wire [8:0] wr_delay = (reg_wdata[8:0] > DELAY_MAX) ? DELAY_MAX : reg_wdata[8:0];

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            sync_seq_if link ();

            assign delay_wr[ch] = reg_wr && hit_channel(reg_addr, DELAY_BASE, ch);
            assign delay_rd[ch] = reg_rd && hit_channel(reg_addr, DELAY_BASE, ch);
            assign cfg_wr[ch] = reg_wr && hit_channel(reg_addr, CHCFG_BASE, ch);
            assign cfg_rd[ch] = reg_rd && hit_channel(reg_addr, CHCFG_BASE, ch);

            // [RULE13] Live write starts a resync unless the channel's sequencer is busy
            assign start[ch] = (delay_wr[ch] && live_ff)
                || (ctrl_wr && reg_wdata[CTRL_START_LSB + ch]);

            if (ch < RELAYED) begin : g_relay_delay
                // [RULE8] Drop sub-period part of delay
                assign eff_delay[ch] = delay_ff[ch] & ~((9'h001 << ratio_ff[ch]) - 9'h001);
            end else begin : g_direct_delay
                // [RULE12] Single-cycle delay steps
                assign eff_delay[ch] = delay_ff[ch];
            end

            assign link.start = start[ch];
            assign link.delay = eff_delay[ch];
            assign busy[ch] = link.busy;
            assign done[ch] = link.done;
            assign sync_enable[ch] = link.sync_en;
            // [RULE4] Pulses to both converters
            assign duc_channel_sync_input[ch] = link.duc_pulse;
            assign ddc_channel_sync_input[ch] = link.ddc_pulse;

            // [RULE2] Sequencer sets the offset
            sync_pulse_seq u_seq (
                .clock(clock),
                .reset(reset),
                .ctl(link.seq)
            );

            // [RULE3] Judged on the values being written, so a read right after sees it
            assign needs_check[ch] = (ctrl_wr ? reg_wdata[CTRL_PARALLEL_BIT] : parallel_iq_mode_ff)
                && ((cfg_wr[ch] ? reg_wdata[CHCFG_DECIM_LSB +: 8] : decim_ff[ch]) > HOLD_MAX);

            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    delay_ff[ch] <= DELAY_RESET;
                end else if (delay_wr[ch]) begin
                    delay_ff[ch] <= wr_delay;
                end
            end

            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    ratio_ff[ch] <= RATIO_RESET;
                    neg_pol_ff[ch] <= 1'b0;
                    decim_ff[ch] <= DECIM_RESET;
                end else if (cfg_wr[ch]) begin
                    ratio_ff[ch] <= reg_wdata[CHCFG_RATIO_LSB +: 3];
                    neg_pol_ff[ch] <= reg_wdata[CHCFG_NEG_BIT];
                    decim_ff[ch] <= reg_wdata[CHCFG_DECIM_LSB +: 8];
                end
            end
        end
    endgenerate

    // Set wins over clear: a config change during the last cycle stays flagged
    always_comb begin
        nxt_need_sync = need_sync_ff & ~done;
        if (ctrl_wr || (|cfg_wr)) begin
            nxt_need_sync = nxt_need_sync | needs_check;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            live_ff <= 1'b0;
            parallel_iq_mode_ff <= 1'b0;
        end else if (ctrl_wr) begin
            live_ff <= reg_wdata[CTRL_LIVE_BIT];
            parallel_iq_mode_ff <= reg_wdata[CTRL_PARALLEL_BIT];
        end
    end

    // Check flag register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            need_sync_ff <= '0;
        end else begin
            need_sync_ff <= nxt_need_sync;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (ctrl_rd) begin
            nxt_rdata[CTRL_LIVE_BIT] = live_ff;
            nxt_rdata[CTRL_PARALLEL_BIT] = parallel_iq_mode_ff;
        end
        if (status_rd) begin
            nxt_rdata[STATUS_BUSY_LSB +: CHANNELS] = busy;
            nxt_rdata[STATUS_NEED_LSB +: CHANNELS] = need_sync_ff;
        end
        for (int i = 0; i < CHANNELS; i++) begin
            if (delay_rd[i]) begin
                nxt_rdata[8:0] = delay_ff[i];
            end
            if (cfg_rd[i]) begin
                nxt_rdata[CHCFG_RATIO_LSB +: 3] = ratio_ff[i];
                nxt_rdata[CHCFG_NEG_BIT] = neg_pol_ff[i];
                nxt_rdata[CHCFG_DECIM_LSB +: 8] = decim_ff[i];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // Relay for channels 1 and 2
    genvar r;
    generate
        for (r = 0; r < RELAYED; r++) begin : g_relay
            logic div_prev_ff;
            logic iq_phase_ff;
            logic strobe_ff;
            logic [DATA_W-1:0] i_ff;
            logic [DATA_W-1:0] q_ff;
            logic nxt_iq_phase;
            logic [DATA_W-1:0] nxt_i;
            logic [DATA_W-1:0] nxt_q;

            wire rise = ddc_div_clk[r] && !div_prev_ff;
            wire fall = !ddc_div_clk[r] && div_prev_ff;
            // [RULE9] Polarity picks the latching edge
            wire latch = neg_pol_ff[r] ? fall : rise;

            // [RULE5] Converter restarts I first after sync
            wire phase_reset = ddc_channel_sync_input[r];

            always_comb begin
                nxt_iq_phase = iq_phase_ff;
                nxt_i = i_ff;
                nxt_q = q_ff;
                if (phase_reset) begin
                    nxt_iq_phase = 1'b0;
                end else if (latch) begin
                    // [RULE7] Latch on the divided clock
                    if (parallel_iq_mode_ff) begin
                        nxt_i = ddc_i_data[r];
                        nxt_q = ddc_q_data[r];
                    end else begin
                        // [RULE1] I then Q on one path
                        nxt_i = iq_phase_ff ? ddc_q_data[r] : ddc_i_data[r];
                        nxt_q = '0;
                        nxt_iq_phase = !iq_phase_ff;
                    end
                end
            end

            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    div_prev_ff <= 1'b0;
                    iq_phase_ff <= 1'b0;
                    strobe_ff <= 1'b0;
                    i_ff <= '0;
                    q_ff <= '0;
                end else begin
                    div_prev_ff <= ddc_div_clk[r];
                    iq_phase_ff <= nxt_iq_phase;
                    strobe_ff <= latch && !phase_reset;
                    i_ff <= nxt_i;
                    q_ff <= nxt_q;
                end
            end

            assign duc_i_data[r] = i_ff;
            assign duc_q_data[r] = q_ff;
            assign duc_data_strobe[r] = strobe_ff;
        end
    endgenerate

endmodule

// >>> verification/sync_delay_aligner_props.sv
// Concurrent checks on the aligner's top-level ports.
// Assumes one clock domain and the package register map.
`timescale 1ns/1ps
module sync_delay_aligner_props
    import sync_align_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Converter sync
    input wire logic [CHANNELS-1:0] ddc_channel_sync_input,
    input wire logic [CHANNELS-1:0] duc_channel_sync_input,
    input wire logic [CHANNELS-1:0] sync_enable,
    // Relay
    input wire logic [RELAYED-1:0] ddc_div_clk,
    input wire logic [RELAYED-1:0][DATA_W-1:0] ddc_i_data,
    input wire logic [RELAYED-1:0][DATA_W-1:0] ddc_q_data,
    input wire logic [RELAYED-1:0][DATA_W-1:0] duc_i_data,
    input wire logic [RELAYED-1:0][DATA_W-1:0] duc_q_data,
    input wire logic [RELAYED-1:0] duc_data_strobe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    duc_in_window_a: assert property (
        (duc_channel_sync_input & ~sync_enable) == 4'h0) else $error("up pulse outside sequence");
    ddc_in_window_a: assert property (
        (ddc_channel_sync_input & ~sync_enable) == 4'h0) else $error("down pulse outside sequence");
    duc_single_a: assert property (
        duc_channel_sync_input[0] |=> !duc_channel_sync_input[0]) else $error("up pulse too long");
    start_arms_a: assert property (
        reg_wr && reg_addr == CTRL_OFFSET && reg_wdata[CTRL_START_LSB] && !sync_enable[0]
        |=> sync_enable[0]) else $error("start did not arm");
    arm_to_duc_a: assert property (
        $rose(sync_enable[0]) |-> ##2 duc_channel_sync_input[0]) else $error("up pulse late");
    ddc_bound_a: assert property (
        duc_channel_sync_input[0] |-> ##[0:256] ddc_channel_sync_input[0])
        else $error("down pulse beyond range");
    no_advance_a: assert property (
        $rose(sync_enable[0]) |-> !ddc_channel_sync_input[0] [*2]) else $error("down pulse early");
    sync_end_a: assert property (
        ddc_channel_sync_input[3] |-> ##[1:3] !sync_enable[3]) else $error("sync stays enabled");
    strobe_single_a: assert property (
        duc_data_strobe[0] |=> !duc_data_strobe[0]) else $error("relay strobe too long");

    cover property (duc_channel_sync_input[0] && ddc_channel_sync_input[0]);
    cover property (ddc_channel_sync_input[3]);
    cover property (duc_data_strobe[1]);
endmodule

bind sync_delay_aligner sync_delay_aligner_props #(.DATA_W(DATA_W)) props_i (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ddc_channel_sync_input(ddc_channel_sync_input),
    .duc_channel_sync_input(duc_channel_sync_input), .sync_enable(sync_enable),
    .ddc_div_clk(ddc_div_clk), .ddc_i_data(ddc_i_data), .ddc_q_data(ddc_q_data),
    .duc_i_data(duc_i_data), .duc_q_data(duc_q_data), .duc_data_strobe(duc_data_strobe)
);

// >>> verification/converter_pair_model.sv
// Down-converter lanes 1 and 2: divided clock and I/Q samples.
// Assumes the aligner's down-converter sync pulses as input.
`timescale 1ns/1ps
module converter_pair_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Sync from the aligner
    input wire logic [3:0] ddc_sync,
    // Relayed lanes
    output logic [1:0] div_clk,
    output logic [1:0][15:0] i_data,
    output logic [1:0][15:0] q_data
);
    logic [1:0][7:0] phase_ff;

    always_ff @(posedge clock or posedge reset) begin
        for (int c = 0; c < 2; c++) begin
            if (reset) begin
                phase_ff[c] <= 8'h00;
            end else begin
                phase_ff[c] <= ddc_sync[c] ? 8'h00 : phase_ff[c] + 8'h01;
            end
        end
    end

    // Upper byte marks I versus Q so interleaving shows at the far end
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            div_clk[c] = phase_ff[c][0];
            i_data[c] = {8'h5A, 1'b0, phase_ff[c][7:1]};
            q_data[c] = {8'hA5, 1'b1, phase_ff[c][7:1]};
        end
    end
endmodule

// >>> verification/test_sync_delay_aligner.sv
// Self-checking bench for the sync delay aligner.
// Assumes the package register map; the model drives lanes 1 and 2.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_sync_delay_aligner;
    import sync_align_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, v;
    logic [3:0] ddc_s, duc_s, sync_enable;
    logic [1:0] div_clk, strobe;
    logic [1:0][15:0] ddc_i, ddc_q, duc_i, duc_q;
    logic [1:0][7:0] last;
    int n_mismatch = 0;
    int check_count = 0;
    int unsigned seed = 46;
    bit mon = 0;
    bit par = 0;
    bit neg = 0;
    int pp[2] = '{0, 0};
    int pn[2] = '{0, 0};

    always #5 clock = ~clock;

    sync_delay_aligner #(.DATA_W(16)) sync_delay_aligner_i (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ddc_channel_sync_input(ddc_s), .duc_channel_sync_input(duc_s),
        .sync_enable(sync_enable), .ddc_div_clk(div_clk), .ddc_i_data(ddc_i),
        .ddc_q_data(ddc_q), .duc_i_data(duc_i), .duc_q_data(duc_q), .duc_data_strobe(strobe)
    );
    converter_pair_model converter_pair_model_i (
        .clock(clock), .reset(reset), .ddc_sync(ddc_s), .div_clk(div_clk),
        .i_data(ddc_i), .q_data(ddc_q)
    );

    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Strobes stay up between back-to-back accesses; bus_idle drops them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge clock);
        #1 d = reg_rdata;
    endtask

    task automatic bus_idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    task automatic sync_check(input int ch, input int d, input bit live, input bit again,
                              input int lg);
        int e, tduc, tddc, nduc;
        e = (d > 256) ? 256 : d;
        if (ch < 2) e = e & ~((1 << lg) - 1);
        tduc = -1;
        tddc = -1;
        nduc = 0;
        wr(DELAY_BASE + 8'(4 * ch), 32'(d));
        if (!live) wr(CTRL_OFFSET, 32'(1) << (4 + ch));
        // Second start lands while busy and must be dropped
        if (again) wr(CTRL_OFFSET, 32'(1) << (4 + ch));
        bus_idle();
        for (int t = 1; t < 300; t++) begin
            @(posedge clock);
            #1;
            if (duc_s[ch]) begin
                tduc = t;
                nduc++;
            end
            if (ddc_s[ch]) tddc = t;
            if (!sync_enable[ch]) break;
        end
        if (sync_enable[ch]) begin
            n_mismatch++;
            tally_and_finish();
        end
        `CHK(tduc, 2 - int'(again))
        `CHK(tddc - tduc, e)
        `CHK(nduc, 1)
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(negedge clock) begin
        for (int c = 0; c < 2; c++) begin
            if (!mon) last[c] = 8'h00;
            if (mon && strobe[c]) begin
                if (par) begin
                    `CHK({duc_i[c][15:8], duc_q[c][15:8]}, 16'h5AA5)
                end else begin
                    `CHK(duc_q[c], 16'h0000)
                    if (last[c] != 8'h00) `CHK(duc_i[c][15:8], last[c] ^ 8'hFF)
                    last[c] = duc_i[c][15:8];
                end
                if (c == 0 && neg) pn[div_clk[0]]++;
                if (c == 0 && !neg) pp[div_clk[0]]++;
            end
        end
    end

    task automatic relay_phase(input bit p, input bit n);
        mon = 0;
        wr(CHCFG_BASE, {27'h20, n, 4'h1});
        wr(CHCFG_BASE + 8'h04, {27'h20, n, 4'h1});
        wr(CTRL_OFFSET, {30'h0, p, 1'b0});
        bus_idle();
        par = p;
        neg = n;
        repeat (4) @(posedge clock);
        mon = 1;
        repeat (40) @(posedge clock);
    endtask

    initial begin
        #500000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(CTRL_OFFSET, v);
        `CHK(v, 32'h0)
        rd(DELAY_BASE, v);
        `CHK(v, 32'h0)
        rd(CHCFG_BASE, v);
        `CHK(v, 32'h401)
        rd(8'h40, v);
        `CHK(v, 32'h0)
        wr(DELAY_BASE + 8'h0C, 32'h1FF);
        rd(DELAY_BASE + 8'h0C, v);
        `CHK(v, 32'h100)
        for (int ch = 0; ch < 4; ch++) begin
            sync_check(ch, 0, 0, 0, 1);
            sync_check(ch, 256, 0, 0, 1);
            sync_check(ch, int'(xs() % 300), 0, 0, 1);
        end
        sync_check(2, 5, 0, 1, 1);
        wr(CHCFG_BASE + 8'h04, 32'h402);
        sync_check(1, 7, 0, 0, 2);
        wr(CTRL_OFFSET, 32'h1);
        sync_check(3, 9, 1, 0, 1);
        sync_check(0, int'(xs() % 256), 1, 0, 1);
        wr(CHCFG_BASE + 8'h08, 32'h1101);
        wr(CHCFG_BASE + 8'h0C, 32'h1001);
        wr(CTRL_OFFSET, 32'h2);
        rd(STATUS_OFFSET, v);
        `CHK(v, 32'h40)
        sync_check(2, 3, 0, 0, 1);
        rd(STATUS_OFFSET, v);
        `CHK(v, 32'h0)
        relay_phase(0, 0);
        relay_phase(0, 1);
        relay_phase(1, 0);
        `CHK(pp[0] * pp[1] + pn[0] * pn[1] == 0 && (pp[0] + pn[0]) * (pp[1] + pn[1]) != 0, 1'b1)
        tally_and_finish();
    end
endmodule
